/* File: logic/i2c_port_defs.svh */
// constants for the i2c slave register port
`ifndef I2C_PORT_DEFS_SVH
`define I2C_PORT_DEFS_SVH
`define SLAVE_ADDR        7'h60
`define HS_CODE_PREFIX    5'h01
`define REG_COUNT         8
`define REG_IDX_W         3
`define PD_REG_IDX        3'h7
`define EN_PULLDOWN_BIT   0
`define SEL_PULLDOWN_BIT  1
`define PD_REG_RESET      8'h03
`define UNMAPPED_VALUE    8'h00
`define IMPL_REG_COUNT    4'h8
`endif

/* File: logic/i2c_port_pkg.sv */
// types for the i2c slave register port
package i2c_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_INDEX = 3'b011,
		ST_DATA  = 3'b010,
		ST_READ  = 3'b110,
		ST_SKIP  = 3'b111
	} phase_t;
	typedef struct packed {
		logic sda_o;
		logic sda_oe;
	} sda_drive_t;
	typedef struct packed {
		logic en_pd;
		logic sel_pd;
	} pulldown_t;
endpackage

/* File: logic/i2c_reg_port.sv */
// i2c slave register port with high-speed mode and input pull-down control
`timescale 1ns/1ps
`include "i2c_port_defs.svh"

module i2c_reg_port (
	input  wire logic ref_clk_i,
	input  wire logic resetn_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic enable_pin_i,
	input  wire logic voltage_select_input_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	output logic      hs_mode_o,
	output logic      enable_pin_pulldown_o,
	output logic      select_pin_pulldown_o,
	output logic      reg_write_o
);
	// resetn_i is the logic-supply undervoltage reset
	logic                  scl_d_r, sda_d_r, scl_d_nxt, sda_d_nxt;
	i2c_port_pkg::phase_t  phase_r, phase_nxt;
	logic [3:0]            bit_cnt_r, bit_cnt_nxt;
	logic [7:0]            shift_r, shift_nxt;
	logic                  ack_r, ack_nxt;
	logic                  hs_r, hs_nxt;
	logic [2:0]            index_r, index_nxt;
	logic [7:0]            regs_r [`REG_COUNT];
	logic [7:0]            regs_nxt [`REG_COUNT];
	logic [7:0]            pend_r, pend_nxt;
	logic                  pend_v_r, pend_v_nxt;
	logic                  wr_r, wr_nxt;
	logic                  mack_r, mack_nxt;
	i2c_port_pkg::sda_drive_t drv_r, drv_nxt;
	i2c_port_pkg::pulldown_t  pd_r, pd_nxt;

	function automatic logic [7:0] read_reg(input logic [2:0] idx, input logic [7:0] v);
		read_reg = (idx == `PD_REG_IDX) ? v : `UNMAPPED_VALUE;
	endfunction

	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_i & ~scl_d_r;
	assign scl_fall = ~scl_i & scl_d_r;
	assign start_c  = scl_i & scl_d_r & sda_d_r & ~sda_i;
	assign stop_c   = scl_i & scl_d_r & ~sda_d_r & sda_i;

	// byte returned for the selected index; unlisted indexes read as zero
	logic [7:0] rd_byte;
	assign rd_byte = read_reg(index_r, regs_r[`PD_REG_IDX]);

	always_comb begin
		scl_d_nxt   = scl_i;
		sda_d_nxt   = sda_i;
		phase_nxt   = phase_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt   = shift_r;
		ack_nxt     = ack_r;
		hs_nxt      = hs_r;
		index_nxt   = index_r;
		regs_nxt    = regs_r;
		pend_nxt    = pend_r;
		pend_v_nxt  = pend_v_r;
		wr_nxt      = 1'b0;
		mack_nxt    = mack_r;
		drv_nxt     = drv_r;
		if (stop_c) begin
			phase_nxt   = i2c_port_pkg::ST_IDLE;
			hs_nxt      = 1'b0;
			drv_nxt     = '0;
			ack_nxt     = 1'b0;
			pend_v_nxt  = 1'b0;
		end else if (start_c) begin
			phase_nxt   = i2c_port_pkg::ST_ADDR;
			bit_cnt_nxt = 4'h0;
			drv_nxt     = '0;
			ack_nxt     = 1'b0;
			pend_v_nxt  = 1'b0;
		end else if (scl_rise && phase_r != i2c_port_pkg::ST_IDLE) begin
			if (bit_cnt_r < 4'h8) begin
				shift_nxt = {shift_r[6:0], sda_i};
			end else begin
				mack_nxt = sda_i;
			end
			bit_cnt_nxt = bit_cnt_r + 4'h1;
		end else if (scl_fall && phase_r != i2c_port_pkg::ST_IDLE) begin
			if (bit_cnt_r == 4'h8) begin
				ack_nxt = 1'b0;
				case (phase_r)
				i2c_port_pkg::ST_ADDR: begin
					if (shift_r[7:3] == `HS_CODE_PREFIX) begin
						hs_nxt    = 1'b1; // no ack
						phase_nxt = i2c_port_pkg::ST_SKIP;
					end else if (shift_r[7:1] == `SLAVE_ADDR) begin
						ack_nxt   = 1'b1;
						phase_nxt = shift_r[0] ? i2c_port_pkg::ST_READ :
						            i2c_port_pkg::ST_INDEX;
					end else begin
						phase_nxt = i2c_port_pkg::ST_SKIP;
					end
				end
				i2c_port_pkg::ST_INDEX: begin
					ack_nxt   = 1'b1;
					index_nxt = shift_r[2:0];
					phase_nxt = i2c_port_pkg::ST_DATA;
				end
				i2c_port_pkg::ST_DATA: begin
					ack_nxt    = 1'b1;
					pend_nxt   = shift_r;
					pend_v_nxt = 1'b1;
				end
				default: begin
					ack_nxt = 1'b0;
				end
				endcase
				drv_nxt.sda_oe = ack_nxt;
				drv_nxt.sda_o  = 1'b0;
				if (phase_r == i2c_port_pkg::ST_READ) begin
					drv_nxt = '0;
				end
			end else if (bit_cnt_r == 4'h9) begin
				bit_cnt_nxt = 4'h0;
				drv_nxt     = '0;
				ack_nxt     = 1'b0;
				if (pend_v_r) begin
					regs_nxt[index_r] = pend_r;
					pend_v_nxt        = 1'b0;
					wr_nxt            = 1'b1;
				end
				if (phase_r == i2c_port_pkg::ST_READ) begin
					if (mack_r) begin
						phase_nxt = i2c_port_pkg::ST_SKIP; // master nack
					end
				end
			end
			// read data driven bit by bit
			if (phase_nxt == i2c_port_pkg::ST_READ && bit_cnt_nxt < 4'h8 &&
			    !(bit_cnt_r == 4'h8)) begin
				drv_nxt.sda_oe = ~rd_byte[3'h7 - bit_cnt_nxt[2:0]];
				drv_nxt.sda_o  = 1'b0;
			end else if (phase_nxt == i2c_port_pkg::ST_READ && bit_cnt_r == 4'h7) begin
				drv_nxt = '0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_d_r   <= 1'b1;
			sda_d_r   <= 1'b1;
			phase_r   <= i2c_port_pkg::ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
			ack_r     <= 1'b0;
			hs_r      <= 1'b0;
			index_r   <= 3'h0;
			for (int i = 0; i < `REG_COUNT; i++) begin
				regs_r[i] <= 8'h00;
			end
			regs_r[`PD_REG_IDX] <= `PD_REG_RESET;
			pend_r    <= 8'h00;
			pend_v_r  <= 1'b0;
			wr_r      <= 1'b0;
			mack_r    <= 1'b0;
			drv_r     <= '0;
		end else begin
			scl_d_r   <= scl_d_nxt;
			sda_d_r   <= sda_d_nxt;
			phase_r   <= phase_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r   <= shift_nxt;
			ack_r     <= ack_nxt;
			hs_r      <= hs_nxt;
			index_r   <= index_nxt;
			regs_r    <= regs_nxt;
			pend_r    <= pend_nxt;
			pend_v_r  <= pend_v_nxt;
			wr_r      <= wr_nxt;
			mack_r    <= mack_nxt;
			drv_r     <= drv_nxt;
		end
	end

	// pull-down control, released while input is high
	always_comb begin
		pd_nxt.en_pd  = regs_r[`PD_REG_IDX][`EN_PULLDOWN_BIT] & ~enable_pin_i;
		pd_nxt.sel_pd = regs_r[`PD_REG_IDX][`SEL_PULLDOWN_BIT] &
		                ~voltage_select_input_i;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pd_r <= '1;
		end else begin
			pd_r <= pd_nxt;
		end
	end

	assign sda_o                 = drv_r.sda_o;
	assign sda_oe_o              = drv_r.sda_oe;
	assign hs_mode_o             = hs_r;
	assign enable_pin_pulldown_o = pd_r.en_pd;
	assign select_pin_pulldown_o = pd_r.sel_pd;
	assign reg_write_o           = wr_r;

	// shift register one clock back, for the checks below
	logic [7:0] shift_r_past;
	always_ff @(posedge ref_clk_i) begin
		shift_r_past <= shift_r;
	end

	hs_no_ack_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(scl_fall && phase_r == i2c_port_pkg::ST_ADDR && bit_cnt_r == 4'h8 &&
		 shift_r[7:3] == `HS_CODE_PREFIX) |=> (hs_mode_o && !sda_oe_o))
		else $error("hs code acknowledged or hs not entered");
	stop_exit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		stop_c |=> !hs_mode_o)
		else $error("hs mode kept after stop");
	addr_ack_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(scl_fall && phase_r == i2c_port_pkg::ST_ADDR && bit_cnt_r == 4'h8 && !start_c &&
		 !stop_c) |=> (sda_oe_o == (shift_r_past == {`SLAVE_ADDR, 1'b0} ||
		 shift_r_past == {`SLAVE_ADDR, 1'b1})))
		else $error("address ack mismatch");
	commit_edge_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		reg_write_o |-> $past(scl_fall) && $past(bit_cnt_r) == 4'h9)
		else $error("write not on ack falling edge");
	pd_high_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		enable_pin_i ##1 enable_pin_i |-> !enable_pin_pulldown_o)
		else $error("pull-down kept on high enable input");
	pd_sel_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(!regs_r[`PD_REG_IDX][`SEL_PULLDOWN_BIT]) |=> !select_pin_pulldown_o)
		else $error("select pull-down not disabled by control bit");
	ack_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(ack_r && scl_rise) |-> (sda_oe_o && !sda_o))
		else $error("ack not held low");
	unmapped_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(phase_r == i2c_port_pkg::ST_READ && index_r != `PD_REG_IDX && bit_cnt_r < 4'h8
		 && !ack_r) |-> sda_oe_o)
		else $error("unmapped register read not zero");

	read_release_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(phase_r == i2c_port_pkg::ST_SKIP)
		|-> !sda_oe_o)
		else $error("data line driven while skipping");

	idle_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(phase_r == i2c_port_pkg::ST_IDLE)
		|-> !sda_oe_o)
		else $error("data line driven while idle");

	index_ack_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(scl_fall && phase_r == i2c_port_pkg::ST_INDEX && bit_cnt_r == 4'h8 && !start_c && !stop_c)
		|=> sda_oe_o)
		else $error("index byte not acknowledged");

	data_ack_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(scl_fall && phase_r == i2c_port_pkg::ST_DATA && bit_cnt_r == 4'h8 && !start_c && !stop_c)
		|=> sda_oe_o)
		else $error("data byte not acknowledged");

	enable_pin_pulldown_ctrl_ctrl_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(!regs_r[`PD_REG_IDX][`EN_PULLDOWN_BIT])
		|=> !enable_pin_pulldown_o)
		else $error("enable pull-down not disabled by control bit");

	pd_sel_high_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		voltage_select_input_i ##1 voltage_select_input_i
		|-> !select_pin_pulldown_o)
		else $error("pull-down kept on high select input");

	hs_from_code_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(hs_mode_o)
		|-> ($past(phase_r) == i2c_port_pkg::ST_ADDR && shift_r_past[7:3] == `HS_CODE_PREFIX))
		else $error("hs mode entered without hs code");

	first_byte_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(start_c && !stop_c)
		|=> (phase_r == i2c_port_pkg::ST_ADDR && bit_cnt_r == 4'h0))
		else $error("byte after start not taken as address");

	ten_bit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(scl_fall && phase_r == i2c_port_pkg::ST_ADDR && bit_cnt_r == 4'h8 &&
		 shift_r[7:3] == 5'h1e && !start_c && !stop_c) |=> !sda_oe_o)
		else $error("ten-bit address acknowledged");

	index_take_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(scl_fall && phase_r == i2c_port_pkg::ST_INDEX && bit_cnt_r == 4'h8 && !start_c && !stop_c)
		|=> (index_r == shift_r_past[2:0]))
		else $error("register index not taken from low bits");
endmodule

/* File: bench/i2c_master_model.sv */
// i2c bus master model: drives scl and pulls sda low
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic ref_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	// ref clocks per scl phase quarter; 8 keeps the bit rate under 3.4 Mbps
	int ph = 8;
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// sda only moves while scl is low
	task automatic clk_bit(input logic d, output logic q);
		wait_n(ph);
		scl_o <= 1'b0;
		wait_n(ph);
		sda_pull_o <= ~d;
		wait_n(ph);
		scl_o <= 1'b1;
		wait_n(ph);
		@(negedge ref_clk_i);
		q = sda_i;
	endtask
	task automatic start_c;
		logic q;
		clk_bit(1'b1, q);
		wait_n(ph);
		sda_pull_o <= 1'b1;
	endtask
	task automatic stop_c;
		logic q;
		clk_bit(1'b0, q);
		wait_n(ph);
		sda_pull_o <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], r[i]);
		end
		clk_bit(1'b1, a);
		// close the ninth clock so the slave sees its falling edge
		wait_n(ph);
		scl_o <= 1'b0;
		wait_n(ph);
	endtask
endmodule

/* File: bench/i2c_reg_port_tb.sv */
// self-checking bench for the i2c slave register port
`timescale 1ns/1ps
module i2c_reg_port_tb;
	logic       ref_clk_i, resetn_i, en_i, sel_i, scl, pull, sda_o, oe, hs, en_pd, sel_pd, wr_p;
	wire        sda = ~pull & ~(oe & ~sda_o);
	int         n_mismatch, samples_checked, cycles, n_wr;
	logic [7:0] rd;
	logic       q;
	i2c_master_model i2c_master_model_inst (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
		.sda_pull_o(pull));
	i2c_reg_port i2c_reg_port_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl),
		.sda_i(sda), .enable_pin_i(en_i), .voltage_select_input_i(sel_i), .sda_o(sda_o),
		.sda_oe_o(oe), .hs_mode_o(hs), .enable_pin_pulldown_o(en_pd),
		.select_pin_pulldown_o(sel_pd), .reg_write_o(wr_p));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic put(input logic [7:0] b, input logic a);
		i2c_master_model_inst.xfer(b, rd, q);
		chk("ack", {7'h00, q}, {7'h00, ~a});
	endtask
	task automatic frame(input logic [7:0] idx, input logic [7:0] d);
		int w;
		w = n_wr;
		put(8'hc0, 1'b1);
		put(idx, 1'b1);
		put(d, 1'b1);
		chk("commit", 8'(n_wr - w), 8'h01);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i2c_master_model_inst.start_c();
		frame(idx, d);
		i2c_master_model_inst.stop_c();
	endtask
	task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
		i2c_master_model_inst.start_c();
		put(8'hc0, 1'b1);
		put(idx, 1'b1);
		i2c_master_model_inst.start_c();
		put(8'hc1, 1'b1);
		i2c_master_model_inst.xfer(8'hff, rd, q);
		chk("read", rd, exp);
		i2c_master_model_inst.stop_c();
		chk("released", {7'h00, oe}, 8'h00);
		chk("sda level", {7'h00, sda_o}, 8'h00);
	endtask
	task automatic pd(input logic e, input logic s);
		repeat (4) @(posedge ref_clk_i);
		chk("pulldowns", {6'h00, en_pd, sel_pd}, {6'h00, e, s});
	endtask
	task automatic t_sense;
		pd(1'b1, 1'b1);
		@(posedge ref_clk_i);
		en_i <= 1'b1;
		pd(1'b0, 1'b1);
		sel_i <= 1'b1;
		en_i <= 1'b0;
		pd(1'b1, 1'b0);
		sel_i <= 1'b0;
		pd(1'b1, 1'b1);
	endtask
	task automatic t_regs;
		wr(8'h07, 8'h02);
		pd(1'b0, 1'b1);
		rd_reg(8'h07, 8'h02);
		wr(8'h07, 8'h01);
		pd(1'b1, 1'b0);
		wr(8'h03, 8'h5a);
		rd_reg(8'h03, 8'h00);
	endtask
	task automatic t_refuse;
		logic [7:0] bad [3] = '{8'hc2, 8'h00, 8'hf0};
		for (int i = 0; i < 3; i++) begin
			i2c_master_model_inst.start_c();
			put(bad[i], 1'b0);
			i2c_master_model_inst.stop_c();
		end
	endtask
	task automatic t_hs;
		i2c_master_model_inst.ph = 250;
		i2c_master_model_inst.start_c();
		put(8'h0d, 1'b0);
		i2c_master_model_inst.ph = 8;
		chk("hs", {7'h00, hs}, 8'h01);
		i2c_master_model_inst.start_c();
		frame(8'h07, 8'h00);
		i2c_master_model_inst.start_c();
		frame(8'h07, 8'h03);
		chk("hs kept", {7'h00, hs}, 8'h01);
		i2c_master_model_inst.stop_c();
		repeat (4) @(posedge ref_clk_i);
		chk("hs off", {7'h00, hs}, 8'h00);
	endtask
	task automatic t_uvlo;
		wr(8'h07, 8'h00);
		pd(1'b0, 1'b0);
		resetn_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		pd(1'b1, 1'b1);
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (wr_p === 1'b1) n_wr++;
		if (cycles == 40000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		{resetn_i, en_i, sel_i} = 3'b000;
		repeat (2) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		t_sense();
		t_regs();
		t_refuse();
		t_hs();
		t_uvlo();
		give_verdict();
	end
endmodule
